// ### shared/ssw_pkg.sv
// constants and lane helpers shared by both ends of the burst sram write port
// assumes a single 20 MHz system clock; the link clocks are derived from it
package ssw_pkg;

  // ---------------------------------------------------------------
  // configuration defaults
  // ---------------------------------------------------------------
  localparam int SSW_DEF_WIDTH  = 36;
  localparam int SSW_DEF_ADDR_W = 4;   // kept small: the array is flip-flops
  localparam int SSW_FIFO_DEPTH = 16;
  localparam int SSW_MAX_LANES  = 4;
  localparam int SSW_NIB_LANES  = 2;

  // ---------------------------------------------------------------
  // link timing: one link clock period is four system clocks
  // ---------------------------------------------------------------
  localparam logic [1:0] SSW_PH_PRE_K  = 2'h3;  // edge that raises k
  localparam logic [1:0] SSW_PH_PRE_KB = 2'h1;  // edge that raises kb

  // ---------------------------------------------------------------
  // controller register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] SSW_REG_WADDR   = 5'h00;
  localparam logic [4:0] SSW_REG_DATA0   = 5'h04;
  localparam logic [4:0] SSW_REG_DATA1   = 5'h08;
  localparam logic [4:0] SSW_REG_MASK    = 5'h0c;
  localparam logic [4:0] SSW_REG_CMD     = 5'h10;
  localparam logic [4:0] SSW_REG_STATUS  = 5'h14;
  localparam logic [4:0] SSW_REG_DATA0_H = 5'h18;
  localparam logic [4:0] SSW_REG_DATA1_H = 5'h1c;
  localparam logic [7:0] SSW_MASK_RESET  = 8'hff;
  localparam int         SSW_ST_NEMPTY   = 0;
  localparam int         SSW_ST_FULL     = 1;
  localparam int         SSW_ST_BUSY     = 2;
  localparam int         SSW_ST_SENT_LSB = 16;

  // ---------------------------------------------------------------
  // lane geometry
  // ---------------------------------------------------------------
  function automatic int ssw_lanes(input int width);
    return (width == 8) ? SSW_NIB_LANES : width / 9;
  endfunction : ssw_lanes

  function automatic int ssw_lane_w(input int width);
    return (width == 8) ? 4 : 9;
  endfunction : ssw_lane_w

  function automatic bit ssw_width_ok(input int width);
    return (width == 8) || (width == 9) || (width == 18) || (width == 36);
  endfunction : ssw_width_ok

endpackage : ssw_pkg

// ### shared/ssw_if.sv
// link between the write-port controller and the sram write port
// assumes both ends run on the same system clock; k and kb are plain signals
`timescale 1ns/100ps
interface ssw_if #(
  parameter int WIDTH  = 36,
  parameter int ADDR_W = 4
);
  logic              k;
  logic              kb;
  logic              write_port_select_n;
  logic [ADDR_W-1:0] addr;
  logic [WIDTH-1:0]  wdata;
  logic [1:0]        nibble_write_mask_n;
  logic [3:0]        byte_lane_write_mask_n;

  modport dev (
    input k,
    input kb,
    input write_port_select_n,
    input addr,
    input wdata,
    input nibble_write_mask_n,
    input byte_lane_write_mask_n
  );

  modport host (
    output k,
    output kb,
    output write_port_select_n,
    output addr,
    output wdata,
    output nibble_write_mask_n,
    output byte_lane_write_mask_n
  );
endinterface : ssw_if

// ### logic/ssw_device.sv
// write-port input stage of a two-word burst sram, array held in flip-flops
// assumes k and kb are sampled on the system clock and change only after an edge
//
// How it works
// - capture data on k and kb, writes only
// - data width is 8, 9, 18 or 36
// - port select sampled on k rise only
// - select low starts a write operation
// - select high: data ignored, array unchanged
// - x8: two nibble masks gate low, high
// - masked nibble keeps its stored value
// - nibble mask sampled with its data
// - wider widths: byte masks gate nine-bit lanes
// - byte mask count is one, two, four
// - masked byte lane keeps stored value
// - masked byte lane data is discarded
// - byte mask sampled with its data
// - each beat uses its own mask
// - write address taken on kb rise
// - address ignored while port deselected
// - accesses start only on k rise
`timescale 1ns/100ps
module ssw_device
  import ssw_pkg::*;
#(
  parameter int WIDTH  = SSW_DEF_WIDTH,
  parameter int ADDR_W = SSW_DEF_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              srst,
  ssw_if.dev                     link,
  input  wire logic [ADDR_W:0]   peek_addr,
  output logic      [WIDTH-1:0]  peek_data,
  output logic                   wr_done,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [15:0]       wr_count,
  output logic      [15:0]       lane_skip_count
);

  // ---------------------------------------------------------------
  // geometry and elaboration checks
  // ---------------------------------------------------------------
  localparam int LANES  = ssw_lanes(WIDTH);
  localparam int LANE_W = ssw_lane_w(WIDTH);
  localparam int WORDS  = 2 ** (ADDR_W + 1);

  if (!ssw_width_ok(WIDTH)) begin : g_bad_width
    $error("ssw_device: WIDTH must be 8, 9, 18 or 36");
  end
  if (ADDR_W < 1 || ADDR_W > 12) begin : g_bad_addr
    $error("ssw_device: ADDR_W must be 1 to 12");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // lane enables, active high, from the pin masks of the present beat
  function automatic logic [3:0] lane_en(input logic [1:0] nib_n,
                                         input logic [3:0] byte_n);
    logic [3:0] en;
    en = 4'h0;
    if (WIDTH == 8) begin
      en[1:0] = ~nib_n;
    end else begin
      for (int i = 0; i < LANES; i++) begin
        en[i] = ~byte_n[i];
      end
    end
    return en;
  endfunction : lane_en

  // masked merge: disabled lanes keep the old word's bits
  function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old_w,
                                             input logic [WIDTH-1:0] new_w,
                                             input logic [3:0]       en);
    logic [WIDTH-1:0] res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      for (int b = 0; b < LANE_W; b++) begin
        if (en[i]) begin
          res[i*LANE_W+b] = new_w[i*LANE_W+b];
        end
      end
    end
    return res;
  endfunction : merge

  function automatic logic [2:0] skipped(input logic [3:0] en);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < LANES; i++) begin
      n = n + {2'h0, ~en[i]};
    end
    return n;
  endfunction : skipped

  // ---------------------------------------------------------------
  // link clock edge detection
  // ---------------------------------------------------------------
  logic k_prev_q;
  logic kb_prev_q;
  logic k_rise;
  logic kb_rise;

  always_ff @(posedge clk) begin
    if (srst) begin
      k_prev_q  <= 1'b0;
      kb_prev_q <= 1'b0;
    end else begin
      k_prev_q  <= link.k;
      kb_prev_q <= link.kb;
    end
  end

  assign k_rise  = link.k & ~k_prev_q;
  assign kb_rise = link.kb & ~kb_prev_q;

  // ---------------------------------------------------------------
  // port select: one burst per selected k period
  // ---------------------------------------------------------------
  logic sel_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_q <= 1'b0;
    end else if (k_rise) begin
      // kb never looks at the select, only k does
      sel_q <= ~link.write_port_select_n;
    end else if (kb_rise) begin
      sel_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // first beat, captured with its own mask on k rise
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] beat0_q;
  logic [3:0]       en0_q;
  logic [3:0]       en1;

  assign en1 = lane_en(link.nibble_write_mask_n, link.byte_lane_write_mask_n);

  always_ff @(posedge clk) begin
    if (srst) begin
      beat0_q <= '0;
      en0_q   <= 4'h0;
    end else if (k_rise && !link.write_port_select_n) begin
      beat0_q <= link.wdata;
      en0_q   <= en1;
    end
  end

  // ---------------------------------------------------------------
  // array: second beat and address on kb rise, both words written then
  // ---------------------------------------------------------------
  // no reset on the array; contents are unknown until written
  logic [WIDTH-1:0]  mem_q [0:WORDS-1];
  logic [ADDR_W:0]   idx0;
  logic [ADDR_W:0]   idx1;
  logic              commit;

  assign commit = kb_rise & sel_q;
  assign idx0   = {link.addr, 1'b0};
  assign idx1   = {link.addr, 1'b1};

  always_ff @(posedge clk) begin
    if (commit) begin
      mem_q[idx0] <= merge(mem_q[idx0], beat0_q, en0_q);
      mem_q[idx1] <= merge(mem_q[idx1], link.wdata, en1);
    end
  end

  // ---------------------------------------------------------------
  // observation outputs
  // ---------------------------------------------------------------
  logic [WIDTH-1:0]  peek_q;
  logic              done_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [15:0]       count_q;
  logic [15:0]       skip_q;

  always_ff @(posedge clk) begin
    peek_q <= mem_q[peek_addr];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      done_q  <= 1'b0;
      waddr_q <= '0;
    end else begin
      done_q <= commit;
      if (commit) begin
        waddr_q <= link.addr;
      end
    end
  end

  // counters wrap; software-facing width kept at 16 bits
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= 16'h0000;
      skip_q  <= 16'h0000;
    end else if (commit) begin
      count_q <= count_q + 16'h0001;
      skip_q  <= skip_q + {13'h0000, skipped(en0_q)} + {13'h0000, skipped(en1)};
    end
  end

  assign peek_data       = peek_q;
  assign wr_done         = done_q;
  assign wr_addr         = waddr_q;
  assign wr_count        = count_q;
  assign lane_skip_count = skip_q;

endmodule : ssw_device

// ### logic/ssw_host.sv
// write-port controller: avalon-mm registers, a command fifo and the link driver
// assumes one system clock; k and kb are divided from it by four
`timescale 1ns/100ps
module ssw_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data,
  output logic      [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (2 ** PW) != DEPTH) begin : g_bad_depth
    $error("ssw_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0]  mem_q [0:DEPTH-1];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rp_q];
  assign level     = cnt_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= push ? wp_q + PW'(1) : wp_q;
      rp_q  <= pop ? rp_q + PW'(1) : rp_q;
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule : ssw_fifo

module ssw_host
  import ssw_pkg::*;
#(
  parameter int WIDTH      = SSW_DEF_WIDTH,
  parameter int ADDR_W     = SSW_DEF_ADDR_W,
  parameter int FIFO_DEPTH = SSW_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        srst,
  ssw_if.host              link,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  localparam int EW = ADDR_W + 2 * WIDTH + 8;

  if (!ssw_width_ok(WIDTH) || ADDR_W < 1 || ADDR_W > 32) begin : g_bad_cfg
    $error("ssw_host: unsupported WIDTH or ADDR_W");
  end

  // ---------------------------------------------------------------
  // avalon slave: every access waits at least one cycle, then completes
  // ---------------------------------------------------------------
  logic [31:0]       waddr_q;
  logic [63:0]       data0_q;
  logic [63:0]       data1_q;
  logic [7:0]        mask_q;
  logic [15:0]       sent_q;
  logic              wait_q;
  logic [31:0]       rdata_q;
  logic [31:0]       rd_val;
  logic              acc;
  logic              is_cmd;
  logic              f_in_ready;
  logic              f_out_valid;
  logic              f_out_ready;
  logic [EW-1:0]     f_out_data;
  logic              busy_q;

  assign acc    = (avs_read | avs_write) & ~wait_q;
  assign is_cmd = avs_write & (avs_address == SSW_REG_CMD);

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (avs_address)
      SSW_REG_WADDR:   rd_val = waddr_q;
      SSW_REG_DATA0:   rd_val = data0_q[31:0];
      SSW_REG_DATA1:   rd_val = data1_q[31:0];
      SSW_REG_DATA0_H: rd_val = data0_q[63:32];
      SSW_REG_DATA1_H: rd_val = data1_q[63:32];
      SSW_REG_MASK:    rd_val = {24'h00_0000, mask_q};
      SSW_REG_STATUS: begin
        rd_val[SSW_ST_NEMPTY]                     = f_out_valid;
        rd_val[SSW_ST_FULL]                       = ~f_in_ready;
        rd_val[SSW_ST_BUSY]                       = busy_q;
        rd_val[SSW_ST_SENT_LSB+:16]               = sent_q;
      end
      default:         rd_val = 32'h0000_0000;
    endcase
  end

  // a command write is held off while the fifo is full
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (!wait_q) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && (!is_cmd || f_in_ready)) begin
      wait_q  <= 1'b0;
      rdata_q <= rd_val;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      waddr_q <= 32'h0000_0000;
      data0_q <= 64'h0;
      data1_q <= 64'h0;
      mask_q  <= SSW_MASK_RESET;
    end else if (acc && avs_write) begin
      unique case (avs_address)
        SSW_REG_WADDR:   waddr_q         <= avs_writedata;
        SSW_REG_DATA0:   data0_q[31:0]   <= avs_writedata;
        SSW_REG_DATA1:   data1_q[31:0]   <= avs_writedata;
        SSW_REG_DATA0_H: data0_q[63:32]  <= avs_writedata;
        SSW_REG_DATA1_H: data1_q[63:32]  <= avs_writedata;
        SSW_REG_MASK:    mask_q          <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;

  // ---------------------------------------------------------------
  // command fifo: {addr, beat1, mask1_n, beat0, mask0_n}
  // ---------------------------------------------------------------
  // masks are inverted on entry so the pins come straight from flops
  ssw_fifo #(.W(EW), .DEPTH(FIFO_DEPTH)) i_ssw_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (acc & is_cmd),
    .in_ready  (f_in_ready),
    .in_data   ({waddr_q[ADDR_W-1:0], data1_q[WIDTH-1:0], ~mask_q[7:4],
                 data0_q[WIDTH-1:0], ~mask_q[3:0]}),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     ()
  );

  // ---------------------------------------------------------------
  // link driver: k high in phases 0-1, kb high in phases 2-3
  // ---------------------------------------------------------------
  logic [1:0]        phase_q;
  logic              k_q;
  logic              kb_q;
  logic              sel_n_q;
  logic [ADDR_W-1:0] addr_q;
  logic [WIDTH-1:0]  wdata_q;
  logic [3:0]        lane_n_q;
  logic [ADDR_W-1:0] b_addr_q;
  logic [WIDTH-1:0]  b_data_q;
  logic [3:0]        b_lane_n_q;

  // pops only just before k rises, so select and first beat leave together
  assign f_out_ready = (phase_q == SSW_PH_PRE_K);

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q <= 2'h0;
      k_q     <= 1'b0;
      kb_q    <= 1'b0;
    end else begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == SSW_PH_PRE_K) begin
        k_q  <= 1'b1;
        kb_q <= 1'b0;
      end else if (phase_q == SSW_PH_PRE_KB) begin
        k_q  <= 1'b0;
        kb_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_n_q    <= 1'b1;
      addr_q     <= '0;
      wdata_q    <= '0;
      lane_n_q   <= 4'hf;
      b_addr_q   <= '0;
      b_data_q   <= '0;
      b_lane_n_q <= 4'hf;
      busy_q     <= 1'b0;
      sent_q     <= 16'h0000;
    end else if (phase_q == SSW_PH_PRE_K) begin
      sel_n_q <= ~f_out_valid;
      busy_q  <= f_out_valid;
      if (f_out_valid) begin
        {b_addr_q, b_data_q, b_lane_n_q, wdata_q, lane_n_q} <= f_out_data;
        sent_q <= sent_q + 16'h0001;
      end
    end else if (phase_q == SSW_PH_PRE_KB && busy_q) begin
      addr_q   <= b_addr_q;
      wdata_q  <= b_data_q;
      lane_n_q <= b_lane_n_q;
    end
  end

  assign link.k                      = k_q;
  assign link.kb                     = kb_q;
  assign link.write_port_select_n    = sel_n_q;
  assign link.addr                   = addr_q;
  assign link.wdata                  = wdata_q;
  assign link.nibble_write_mask_n    = lane_n_q[1:0];
  assign link.byte_lane_write_mask_n = lane_n_q;

endmodule : ssw_host

// ### verification/ssw_link_chk.sv
// link checker: select, address, data and mask timing against the k and kb phases
// assumes every link signal comes from system clock flops of the controller
`timescale 1ns/100ps
module ssw_link_chk #(
  parameter int WIDTH  = 36,
  parameter int ADDR_W = 4
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic              k,
  input wire logic              kb,
  input wire logic              write_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [WIDTH-1:0]  wdata,
  input wire logic [1:0]        nibble_write_mask_n,
  input wire logic [3:0]        byte_lane_write_mask_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // ---------------------------------------------------------------
  // link phases
  // ---------------------------------------------------------------
  a_k_phase_len: assert property ($rose(k) |-> k [*2] ##1 (!k) [*2] ##1 k)
    else $error("k phase length wrong");
  a_kb_follows_k: assert property ($rose(k) |-> !kb ##2 $rose(kb))
    else $error("kb did not rise two cycles after k");

  // ---------------------------------------------------------------
  // what may change at which edge
  // ---------------------------------------------------------------
  a_sel_on_k: assert property ($changed(write_port_select_n) |-> $rose(k))
    else $error("select changed away from a k rise");
  a_sel_whole_period: assert property ($fell(write_port_select_n) |->
    (!write_port_select_n) [*4])
    else $error("select low for less than one link period");
  a_addr_on_kb: assert property ($changed(addr) |-> $rose(kb))
    else $error("address changed away from a kb rise");
  a_data_on_edge: assert property ($changed(wdata) |-> $rose(k) || $rose(kb))
    else $error("data changed away from a link edge");
  a_byte_mask_beat: assert property ($changed(byte_lane_write_mask_n) |->
    $rose(k) || $rose(kb))
    else $error("byte mask changed away from its data edge");
  a_nib_mask_beat: assert property ($changed(nibble_write_mask_n) |->
    $rose(k) || $rose(kb))
    else $error("nibble mask changed away from its data edge");

  c_burst: cover property ($fell(write_port_select_n));
  c_back_to_back: cover property ((!write_port_select_n) [*5]);
  c_part_mask: cover property ($rose(kb) && !write_port_select_n &&
    byte_lane_write_mask_n != 4'h0 && byte_lane_write_mask_n != 4'hf);
endmodule : ssw_link_chk

// ### verification/sync_sram_write_port_masking_bench.sv
// bench: controller and sram joined by the link, driven over avalon-mm
// assumes the default 36-bit width; expectations come from a lane model here
`timescale 1ns/100ps
module sync_sram_write_port_masking_bench;
  import ssw_pkg::*;
  localparam int W  = SSW_DEF_WIDTH;
  localparam int AW = SSW_DEF_ADDR_W;
  logic          clk;
  logic          srst          = 1'b1;
  logic          avs_read      = 1'b0;
  logic          avs_write     = 1'b0;
  logic [4:0]    avs_address   = 5'h00;
  logic [31:0]   avs_writedata = 32'h0;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic [AW:0]   peek_addr     = '0;
  logic [W-1:0]  peek_data;
  logic          wr_done;
  logic [AW-1:0] wr_addr;
  logic [15:0]   wr_count;
  logic [15:0]   lane_skip_count;
  logic [15:0]   exp_cnt       = 16'h0;
  logic [15:0]   exp_skip      = 16'h0;
  logic [31:0]   rd;
  logic [W-1:0]  mem [2**(AW+1)];
  int            num_errors    = 0;
  int            check_count   = 0;
  int            longest       = 0;
  logic [15:0]   done_seen     = 16'h0;

  ssw_if #(.WIDTH(W), .ADDR_W(AW)) link_if ();
  ssw_host #(.WIDTH(W), .ADDR_W(AW), .FIFO_DEPTH(SSW_FIFO_DEPTH)) i_ssw_host (
    .clk(clk), .srst(srst), .link(link_if.host), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  ssw_device #(.WIDTH(W), .ADDR_W(AW)) i_ssw_device (
    .clk(clk), .srst(srst), .link(link_if.dev), .peek_addr(peek_addr),
    .peek_data(peek_data), .wr_done(wr_done), .wr_addr(wr_addr),
    .wr_count(wr_count), .lane_skip_count(lane_skip_count));
  ssw_link_chk #(.WIDTH(W), .ADDR_W(AW)) u_chk (
    .clk(clk), .srst(srst), .k(link_if.k), .kb(link_if.kb),
    .write_port_select_n(link_if.write_port_select_n), .addr(link_if.addr),
    .wdata(link_if.wdata), .nibble_write_mask_n(link_if.nibble_write_mask_n),
    .byte_lane_write_mask_n(link_if.byte_lane_write_mask_n));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one avalon access; waitrequest and read data are taken at the same rising edge
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n > longest) longest = n;
    if (n >= 200) check("waitrequest", 1, 0);
  endtask : av

  // one count per cycle that wr_done stands high
  always @(posedge clk) begin
    if (wr_done === 1'b1) done_seen <= done_seen + 16'h1;
  end

  function automatic logic [W-1:0] merge(input logic [W-1:0] old, nw, input logic [3:0] en);
    logic [W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (en[i]) r[i*9 +: 9] = nw[i*9 +: 9];
    return r;
  endfunction : merge

  task automatic burst(input logic [AW-1:0] a, input logic [W-1:0] d0, d1,
                       input logic [7:0] m);
    av(1'b1, SSW_REG_WADDR, 32'(a));
    av(1'b1, SSW_REG_DATA0, d0[31:0]);
    av(1'b1, SSW_REG_DATA0_H, 32'(d0[W-1:32]));
    av(1'b1, SSW_REG_DATA1, d1[31:0]);
    av(1'b1, SSW_REG_DATA1_H, 32'(d1[W-1:32]));
    av(1'b1, SSW_REG_MASK, {24'h0, m});
    av(1'b1, SSW_REG_CMD, 32'h0);
    mem[{a, 1'b0}] = merge(mem[{a, 1'b0}], d0, m[3:0]);
    mem[{a, 1'b1}] = merge(mem[{a, 1'b1}], d1, m[7:4]);
    exp_cnt++;
    exp_skip += 16'(8 - $countones(m));
  endtask : burst

  task automatic settle();
    int n;
    n = 0;
    while (wr_count !== exp_cnt && n < 2000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    check("wr_count", 64'(wr_count), 64'(exp_cnt));
    check("lane_skip_count", 64'(lane_skip_count), 64'(exp_skip));
    check("wr_done pulses", 64'(done_seen), 64'(exp_cnt));
  endtask : settle

  task automatic peek(input logic [AW:0] i);
    @(posedge clk);
    peek_addr <= i;
    @(posedge clk);
    @(negedge clk);
    check("peek_data", 64'(peek_data), 64'(mem[i]));
  endtask : peek

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    av(1'b0, SSW_REG_MASK, 32'h0);
    check("mask reset", 64'(rd), 64'(SSW_MASK_RESET));
    av(1'b0, SSW_REG_STATUS, 32'h0);
    check("status reset", 64'(rd), 64'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_plain();
    for (int a = 0; a < 4; a++)
      burst(AW'(a), 36'h9_1234_5670 + 36'(a), 36'h6_edcb_a980 - 36'(a), 8'hff);
    settle();
    check("wr_addr", 64'(wr_addr), 64'h3);
    for (int i = 0; i < 8; i++) peek((AW+1)'(i));
    $display("t_plain done");
  endtask : t_plain

  task automatic t_masks();
    burst(AW'(5), 36'h0, 36'h0, 8'hff);
    burst(AW'(6), 36'h5_a5a5_a5a5, 36'h3_c3c3_c3c3, 8'hff);
    burst(AW'(5), 36'hf_ffff_ffff, 36'hf_ffff_ffff, 8'h5a);
    burst(AW'(6), 36'h0, 36'hf_ffff_ffff, 8'h00);
    settle();
    for (int i = 10; i < 14; i++) peek((AW+1)'(i));
    $display("t_masks done");
  endtask : t_masks

  task automatic t_idle();
    repeat (40) @(posedge clk);
    @(negedge clk);
    check("idle wr_count", 64'(wr_count), 64'(exp_cnt));
    peek('0);
    $display("t_idle done");
  endtask : t_idle

  // pushes come every 3 cycles and pops every 4, so the fifo fills and stalls
  task automatic t_fifo();
    for (int i = 0; i < 70; i++) begin
      av(1'b1, SSW_REG_CMD, 32'h0);
      exp_cnt++;
      exp_skip += 16'h8;
    end
    check("fifo stall", 64'(longest > 2), 64'h1);
    settle();
    av(1'b0, SSW_REG_STATUS, 32'h0);
    check("fifo empty", 64'(rd[SSW_ST_NEMPTY]), 64'h0);
    check("bursts sent", 64'(rd[31:16]), 64'(exp_cnt));
    peek((AW+1)'(12));
    $display("t_fifo done");
  endtask : t_fifo

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // clock, watchdog, main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #1000000;
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_plain();
    t_masks();
    t_idle();
    t_fifo();
    stop_test();
  end
endmodule : sync_sram_write_port_masking_bench
